//--- hw/sgc_top.sv
// Purpose: global control registers 0x02/0x03 with spi slave and their effects
// Assumes: spi pins and frame inputs synchronous to core_clk, spi clock <= core/4
// Notes:   spi mode 0 framing: command, address, then data bytes, auto increment
`default_nettype none
module sgc_top
	import sgc_pkg::*;
#(
	parameter logic [35:0] AGE_NORM_CYCLES = AGE_NORM_CYC, // shorten for simulation
	parameter logic [35:0] FAST_AGE_CYCLES = FAST_AGE_CYC  // shorten for simulation
) (
	input  wire logic                 core_clk,          // core clock
	input  wire logic                 rst_b,             // async reset, low
	input  wire logic                 spi_clk,           // spi serial clock
	input  wire logic                 spi_cs_b,          // spi select, low
	input  wire logic                 spi_mosi,          // spi data in
	output var  logic                 spi_miso,          // spi data out
	output var  logic                 spi_miso_oe_b,     // low while driving miso
	input  wire logic                 port5_if_strap,    // port-5 enable strap
	input  wire logic                 aging_en_strap,    // aging enable strap
	input  wire logic                 pause_dis_strap,   // pause disable strap
	input  wire logic                 tag_valid,         // tagged frame seen
	input  wire logic [2:0]           user_prio,         // its user priority
	output var  logic                 prio_valid,        // classification valid
	output var  logic                 prio_high,         // high priority class
	input  wire logic [P5_OUT_W-1:0]  p5_core_out,       // port-5 outputs from mac
	output var  logic [P5_OUT_W-1:0]  p5_pin_out,        // port-5 pin values
	output var  logic [P5_OUT_W-1:0]  p5_pin_oe_b,       // low while driving pins
	output var  logic [9:0]           buf_port_limit,    // blocks one port may hold
	input  wire sgc_hdr_t             frame_hdr,         // parsed frame header
	output var  logic                 verdict_valid,     // verdict strobe
	output var  logic                 verdict_drop,      // frame is discarded
	input  wire logic [NUM_PORTS-1:0] link_up,           // per-port link state
	output var  logic                 flush_all,         // age out whole table
	output var  logic                 age_tick,          // run one age sweep
	output var  logic                 fast_age_active,   // fast cycle pending
	output var  logic                 aging_on,          // aging running
	input  wire logic                 an_tx_pause,       // negotiated tx pause
	input  wire logic                 an_rx_pause,       // negotiated rx pause
	output var  logic                 tx_fc_en,          // tx flow control on
	output var  logic                 rx_fc_en           // rx flow control on
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sgc_gc0_t    gc0;          // global_control_zero
	sgc_gc1_t    gc1;          // global_control_one
	logic        strap_done;   // straps already loaded
	sgc_spi_t    spi_st;       // spi byte phase
	logic        sclk_q;       // previous spi clock level
	logic [2:0]  bit_cnt;      // bits of current byte
	logic [6:0]  rx_sh;        // incoming bits
	logic [7:0]  tx_sh;        // outgoing bits
	logic        is_read;      // current command reads
	logic [7:0]  reg_addr;     // current register address
	logic [NUM_PORTS-1:0] link_q; // previous link state
	logic [35:0] age_cnt;      // aging period counter

	// spi edge and byte decode
	wire        sclk_rise = spi_clk & ~sclk_q & ~spi_cs_b;
	wire        sclk_fall = ~spi_clk & sclk_q & ~spi_cs_b;
	wire        byte_done = sclk_rise & (bit_cnt == 3'h7);
	wire [7:0]  rx_byte   = {rx_sh, spi_mosi};
	wire        cmd_ok    = (rx_byte == SPI_CMD_WR) | (rx_byte == SPI_CMD_RD);
	wire        wr_strobe = byte_done & (spi_st == SPI_DATA) & ~is_read;
	wire        wr_gc0    = wr_strobe & (reg_addr == GC0_ADDR);
	wire        wr_gc1    = wr_strobe & (reg_addr == GC1_ADDR);
	// address whose data is loaded into the shifter next
	wire [7:0]  rd_addr   = (spi_st == SPI_ADDR) ? rx_byte : 8'(reg_addr + 8'h01);
	// unmapped addresses read back as zero
	wire [7:0]  rd_data   = (rd_addr == GC0_ADDR) ? gc0 :
	                        (rd_addr == GC1_ADDR) ? gc1 : 8'h00;
	wire        rd_load   = byte_done & is_read & ((spi_st == SPI_ADDR) | (spi_st == SPI_DATA));

	// spi clock history; pins are synchronous so one stage suffices
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			// low matches the idle clock, so no false edge
			sclk_q <= 1'h0;
		end else begin
			sclk_q <= spi_clk;
		end
	end

	// byte phase machine, restarted whenever select is released
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			spi_st  <= SPI_CMD;
			bit_cnt <= 3'h0;
			rx_sh   <= 7'h00;
			is_read <= 1'h0;
		end else if (spi_cs_b) begin
			// released select drops any partial byte
			spi_st  <= SPI_CMD;
			bit_cnt <= 3'h0;
		end else if (sclk_rise) begin
			// one bit in per detected rise, msb first
			bit_cnt <= 3'(bit_cnt + 3'h1);
			rx_sh   <= rx_byte[6:0];
			if (byte_done) begin
				unique case (spi_st)
					SPI_CMD: begin
						// only the two known commands open a frame
						spi_st  <= cmd_ok ? SPI_ADDR : SPI_SKIP;
						is_read <= (rx_byte == SPI_CMD_RD);
					end
					SPI_ADDR: spi_st <= SPI_DATA;
					SPI_DATA: spi_st <= SPI_DATA;
					SPI_SKIP: spi_st <= SPI_SKIP; // unknown command ignored
				endcase
			end
		end
	end

	// register address, auto incremented per data byte for bursts
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_addr <= 8'h00;
		end else if (byte_done & (spi_st == SPI_ADDR)) begin
			// second byte names the first register
			reg_addr <= rx_byte;
		end else if (byte_done & (spi_st == SPI_DATA)) begin
			// each further byte moves one place on
			reg_addr <= 8'(reg_addr + 8'h01);
		end
	end

	// read shifter: loaded on a byte boundary, bits leave on falling edges
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_sh         <= 8'h00;
			spi_miso      <= 1'h0;
			// miso released until selected
			spi_miso_oe_b <= 1'h1;
		end else begin
			spi_miso_oe_b <= spi_cs_b; // only drive while selected
			if (rd_load) begin
				// whole byte in place before its first fall
				tx_sh <= rd_data;
			end else if (sclk_fall) begin
				// miso changes only on falls, stable at rises
				spi_miso <= tx_sh[7];
				tx_sh    <= {tx_sh[6:0], 1'h0};
			end
		end
	end

	// control registers; straps load once on the first edge after release
	// so a strap level is never fed into the asynchronous reset path
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			strap_done <= 1'h0;
			gc0        <= '{rsvd: 1'h0, base_prio: BASE_PRIO_RST, port5_if_en: 1'h0,
			                buf_share: BUF_SHARE_RST, conf_drop: 1'h0, link_chg_age: 1'h0};
			gc1        <= '0;
		end else if (!strap_done) begin
			// one cycle only: a write landing here is lost
			// hosts start a frame from the second edge on
			strap_done      <= 1'h1;
			gc0.port5_if_en <= port5_if_strap;
			gc1.aging_en    <= aging_en_strap;
			gc1.tx_pause_dis <= pause_dis_strap;
			gc1.rx_pause_dis <= pause_dis_strap;
		end else begin
			if (wr_gc0) begin
				// whole byte; reserved bit stored as written
				gc0 <= rx_byte;
			end
			if (wr_gc1) begin
				// pause bits now free of their shared strap
				gc1 <= rx_byte; // bits written independently
			end
		end
	end

	// frame classification and port-5 isolation
	wire conf_hit = (frame_hdr.type_len == PAUSE_TYPE) | (frame_hdr.dest_addr == PAUSE_DA);
	wire fc_drop  = gc0.conf_drop ? conf_hit : frame_hdr.is_flow_ctrl;
	wire len_bad  = gc1.len_check & (frame_hdr.type_len < LEN_LIMIT) &
	                (frame_hdr.type_len != frame_hdr.actual_len);
	// pass-all overrides every discard so a sniffer sees all traffic
	wire next_drop = ~gc1.pass_all & (fc_drop | len_bad | frame_hdr.errored);

	// every effect is registered so each output leaves a flip-flop
	// a register write reaches these pins one cycle after it lands
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			// pins isolated and pool shared while in reset
			prio_valid     <= 1'h0;
			prio_high      <= 1'h0;
			p5_pin_out     <= '0;
			p5_pin_oe_b    <= '1;
			buf_port_limit <= POOL_BLOCKS;
			verdict_valid  <= 1'h0;
			verdict_drop   <= 1'h0;
			tx_fc_en       <= 1'h0;
			rx_fc_en       <= 1'h0;
		end else begin
			prio_valid     <= tag_valid;
			prio_high      <= tag_valid & (user_prio >= gc0.base_prio);
			p5_pin_out     <= gc0.port5_if_en ? p5_core_out : '0;
			p5_pin_oe_b    <= {P5_OUT_W{~gc0.port5_if_en}};
			buf_port_limit <= gc0.buf_share ? POOL_BLOCKS : POOL_FIFTH;
			verdict_valid  <= frame_hdr.valid;
			verdict_drop   <= frame_hdr.valid & next_drop;
			tx_fc_en       <= an_tx_pause & ~gc1.tx_pause_dis;
			rx_fc_en       <= an_rx_pause & ~gc1.rx_pause_dis;
		end
	end

	// aging: link loss flushes, optionally runs one fast cycle, then normal
	wire        link_drop = |(link_q & ~link_up);
	wire        fast_req  = link_drop & gc0.link_chg_age;
	wire [35:0] period    = fast_age_active ? FAST_AGE_CYCLES : AGE_NORM_CYCLES;
	wire        run_age   = gc1.aging_en | fast_age_active;
	wire        period_end = run_age & (age_cnt >= 36'(period - 36'h1));

	// flush and fast cycle both start on the loss itself
	// link_q resets low so a rising link is never a loss
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			link_q          <= '0;
			age_cnt         <= '0;
			age_tick        <= 1'h0;
			flush_all       <= 1'h0;
			fast_age_active <= 1'h0;
			aging_on        <= 1'h0;
		end else begin
			link_q    <= link_up;
			flush_all <= link_drop;
			aging_on  <= gc1.aging_en;
			age_tick  <= period_end & ~fast_req;
			if (fast_req) begin
				// a second loss restarts the fast cycle
				fast_age_active <= 1'h1; // set wins over completion
				age_cnt         <= '0;
			end else if (period_end) begin
				// one sweep per period end
				fast_age_active <= 1'h0; // back to normal period
				age_cnt         <= '0;
			end else if (run_age) begin
				// counter holds while aging is off
				age_cnt <= 36'(age_cnt + 36'h1);
			end
		end
	end

	// checks beside the logic they guard
	AST_PRIO_CLASS: assert property (tag_valid |=> prio_high == ($past(user_prio) >= $past(gc0.base_prio)))
		else $error("priority class wrong");
	AST_PRIO_VALID: assert property (tag_valid |=> prio_valid)
		else $error("priority strobe missing");

	// port-5 pins and buffer cap
	AST_P5_ISOLATE: assert property (strap_done && !gc0.port5_if_en |=> p5_pin_oe_b == '1 && p5_pin_out == '0)
		else $error("port-5 pins driven while disabled");
	AST_P5_DRIVE: assert property (gc0.port5_if_en |=> p5_pin_oe_b == '0
		&& p5_pin_out == $past(p5_core_out))
		else $error("port-5 pins not driven while enabled");
	// strap defaults taken once at release
	AST_STRAP_LOAD: assert property ($rose(strap_done) |-> gc0.port5_if_en == $past(port5_if_strap)
		&& gc1.aging_en == $past(aging_en_strap) && gc1.tx_pause_dis == $past(pause_dis_strap)
		&& gc1.rx_pause_dis == $past(pause_dis_strap))
		else $error("strap not loaded at release");
	AST_STRAP_ONCE: assert property (strap_done |=> strap_done)
		else $error("straps sampled again");
	AST_BUF_CAP: assert property (##1 !gc0.buf_share && $stable(gc0) |=> buf_port_limit == POOL_FIFTH)
		else $error("buffer cap not one fifth");
	AST_BUF_SHARE: assert property (gc0.buf_share |=> buf_port_limit == POOL_BLOCKS)
		else $error("shared pool not offered");

	// frame verdicts
	AST_CONF_DROP: assert property (frame_hdr.valid && gc0.conf_drop && !gc1.pass_all
		&& frame_hdr.type_len == PAUSE_TYPE |=> verdict_valid && verdict_drop)
		else $error("pause type frame kept");
	AST_FC_DROP: assert property (frame_hdr.valid && !gc0.conf_drop && frame_hdr.is_flow_ctrl
		&& !gc1.pass_all |=> verdict_valid && verdict_drop)
		else $error("flow control frame kept");
	AST_PASS_ALL: assert property (frame_hdr.valid && gc1.pass_all |=> verdict_valid && !verdict_drop)
		else $error("frame dropped in pass-all");

	// aging and flush
	AST_FAST_AGE: assert property (fast_req |=> fast_age_active && age_cnt == '0)
		else $error("fast age not started");
	AST_FAST_END: assert property (fast_age_active && period_end && !fast_req |=> !fast_age_active && age_tick)
		else $error("fast cycle did not end in a sweep");
	AST_FLUSH: assert property (link_drop |=> flush_all)
		else $error("flush not pulsed on link loss");
	AST_FLUSH_QUIET: assert property (!link_drop |=> !flush_all)
		else $error("flush without link loss");

	// pause overrides
	AST_TX_PAUSE: assert property (gc1.tx_pause_dis ##1 gc1.tx_pause_dis |-> !tx_fc_en)
		else $error("tx flow control on while disabled");
	AST_TX_HONOUR: assert property (an_tx_pause && !gc1.tx_pause_dis |=> tx_fc_en)
		else $error("tx flow control not honoured");
	AST_RX_PAUSE: assert property (an_rx_pause && !gc1.rx_pause_dis |=> rx_fc_en)
		else $error("rx flow control not honoured");
	AST_RX_OFF: assert property (gc1.rx_pause_dis |=> !rx_fc_en)
		else $error("rx flow control on while disabled");

	// length check, aging enable and spi pin
	AST_LEN_DROP: assert property (frame_hdr.valid && len_bad && !gc1.pass_all |=> verdict_drop)
		else $error("length mismatch kept");
	AST_AGING_OFF: assert property (!gc1.aging_en && !fast_age_active |=> !age_tick)
		else $error("age sweep while aging disabled");
	AST_AGING_MIRROR: assert property (gc1.aging_en |=> aging_on)
		else $error("aging flag not following its bit");
	AST_MISO_HIZ: assert property (spi_cs_b |=> spi_miso_oe_b)
		else $error("miso driven while deselected");
endmodule
`default_nettype wire

//--- hw/sgc_pkg.sv
// Purpose: constants and types for the switch global control register pair
// Assumes: 40 MHz core clock, SPI pins already synchronous to it
// Notes:   offsets are byte addresses of the SPI register space
// Functional notes
// - user priority at or above base is high
// - port-5 interface driven only when enabled
// - port-5 enable default follows its strap
// - buffer share on: pool shared; off: one fifth
// - conformance drop selects which control frames drop
// - link loss triggers one fast age cycle
// - any link loss ages out all addresses
// - pass-all forwards errored frames too, resets 0
// - transmit pause disable overrides negotiation result
// - receive pause disable overrides negotiation result
// - both pause disables default from one strap
// - length check drops mismatching short-length frames
// - aging enable bit, default from its strap
// - registers reached over SPI slave only
`default_nettype none
package sgc_pkg;
	// register map
	localparam logic [7:0]  GC0_ADDR      = 8'h02;     // global_control_zero
	localparam logic [7:0]  GC1_ADDR      = 8'h03;     // global_control_one
	localparam logic [7:0]  SPI_CMD_WR    = 8'h02;     // spi write command
	localparam logic [7:0]  SPI_CMD_RD    = 8'h03;     // spi read command
	localparam logic [2:0]  BASE_PRIO_RST = 3'h4;      // base priority reset
	localparam logic        BUF_SHARE_RST = 1'h1;      // buffer share reset
	// frame constants
	localparam logic [15:0] PAUSE_TYPE    = 16'h8808;  // mac control type
	localparam logic [47:0] PAUSE_DA      = 48'h0180C2000001; // pause group address
	localparam logic [15:0] LEN_LIMIT     = 16'h05DC;  // 1500, below is a length
	// buffer pool
	localparam logic [9:0]  POOL_BLOCKS   = 10'h200;   // pool size in blocks
	localparam logic [9:0]  POOL_FIFTH    = 10'(POOL_BLOCKS / 5); // per-port cap
	localparam int          NUM_PORTS     = 5;         // switch ports
	localparam int          P5_OUT_W      = 8;         // port-5 output pins
	// aging times
	localparam longint      CLK_HZ        = 40000000;  // core clock rate
	localparam longint      AGE_NORMAL_S  = 300;       // normal age period
	localparam longint      AGE_EXTRA_S   = 75;        // added age slack
	localparam longint      FAST_AGE_US   = 800;       // fast age upper bound
	localparam logic [35:0] AGE_NORM_CYC  = 36'((AGE_NORMAL_S + AGE_EXTRA_S) * CLK_HZ);
	// strictly shorter than the bound, hence the minus one
	localparam logic [35:0] FAST_AGE_CYC  = 36'(FAST_AGE_US * (CLK_HZ / 1000000) - 1);

	typedef struct packed {
		logic       rsvd;          // bit 7
		logic [2:0] base_prio;     // bits 6:4
		logic       port5_if_en;   // bit 3
		logic       buf_share;     // bit 2
		logic       conf_drop;     // bit 1
		logic       link_chg_age;  // bit 0
	} sgc_gc0_t;

	typedef struct packed {
		logic       pass_all;      // bit 7
		logic       rsvd;          // bit 6
		logic       tx_pause_dis;  // bit 5
		logic       rx_pause_dis;  // bit 4
		logic       len_check;     // bit 3
		logic       aging_en;      // bit 2
		logic [1:0] low_bits;      // bits 1:0, plain storage
	} sgc_gc1_t;

	typedef struct packed {
		logic        valid;        // header present this cycle
		logic [15:0] type_len;     // type/length field
		logic [47:0] dest_addr;    // destination address
		logic        is_flow_ctrl; // parser says flow control
		logic        errored;      // crc or symbol error
		logic [15:0] actual_len;   // measured payload length
	} sgc_hdr_t;

	typedef enum logic [1:0] {
		SPI_CMD  = 2'b00,
		SPI_ADDR = 2'b01,
		SPI_DATA = 2'b11,
		SPI_SKIP = 2'b10
	} sgc_spi_t;
endpackage
`default_nettype wire

//--- testbench/sgc_spi_host.sv
// Purpose: management host model sending whole spi frames to the switch
// Assumes: spi mode 0, clock low 3 and high 3 core cycles
// Notes:   mosi turns to the inverse of its last bit once deselected
`default_nettype none
module sgc_spi_host (
	input  wire logic core_clk, // core clock
	output var  logic spi_clk,  // spi clock, idles low
	output var  logic spi_cs_b, // select, low
	output var  logic spi_mosi, // data to switch
	input  wire logic spi_miso  // data from switch
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle bus at time zero
	initial begin
		spi_clk = 1'b0;
		spi_cs_b = 1'b1;
		spi_mosi = 1'b0;
	end
	// command, address, one data byte, msb first
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] adr, input logic [7:0] wd, output logic [7:0] rd);
		logic [23:0] sh;
		sh = {cmd, adr, wd};
		@(posedge core_clk) spi_cs_b <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			@(posedge core_clk) spi_clk <= 1'b0;
			spi_mosi <= sh[i];
			repeat (3) @(posedge core_clk);
			rd = {rd[6:0], spi_miso}; // taken just before the rise
			spi_clk <= 1'b1;
			repeat (2) @(posedge core_clk);
		end
		@(posedge core_clk) spi_clk <= 1'b0;
		repeat (2) @(posedge core_clk);
		spi_cs_b <= 1'b1;
		spi_mosi <= ~spi_mosi; // a released line must not keep its level
		repeat (2) @(posedge core_clk);
	endtask
endmodule
`default_nettype wire

//--- testbench/switch_global_control_regs_bench.sv
// Purpose: self-checking bench for the global control register pair
// Assumes: shortened aging counts, spi host model beside the block
// Notes:   straps flip after each reset release to show one-shot sampling
`default_nettype none
module switch_global_control_regs_bench
	import sgc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [35:0] NORM = 36'h28; // short normal age period
	localparam logic [35:0] FAST = 36'h8;  // short fast age cycle
	localparam logic [47:0] DA   = 48'h0200000000AA; // plain unicast
	logic       core_clk, rst_b, spi_clk, spi_cs_b, spi_mosi, spi_miso, spi_miso_oe_b; // clock, reset, spi
	logic       port5_if_strap, aging_en_strap, pause_dis_strap; // straps
	logic       tag_valid, prio_valid, prio_high, verdict_valid, verdict_drop; // frame side
	logic       flush_all, age_tick, fast_age_active, aging_on; // aging side
	logic       an_tx_pause, an_rx_pause, tx_fc_en, rx_fc_en; // pause side
	logic [2:0] user_prio;   // tag priority
	logic [7:0] p5_core_out, p5_pin_out, p5_pin_oe_b; // port-5 pins
	logic [9:0] buf_port_limit; // buffer cap
	logic [4:0] link_up;     // link levels
	sgc_hdr_t   frame_hdr;   // header in
	int         failures, n_tests; // tallies
	sgc_top #(.AGE_NORM_CYCLES(NORM), .FAST_AGE_CYCLES(FAST)) dut (
		.core_clk, .rst_b, .spi_clk, .spi_cs_b, .spi_mosi, .spi_miso, .spi_miso_oe_b,
		.port5_if_strap, .aging_en_strap, .pause_dis_strap, .tag_valid, .user_prio,
		.prio_valid, .prio_high, .p5_core_out, .p5_pin_out, .p5_pin_oe_b, .buf_port_limit,
		.frame_hdr, .verdict_valid, .verdict_drop, .link_up, .flush_all, .age_tick,
		.fast_age_active, .aging_on, .an_tx_pause, .an_rx_pause, .tx_fc_en, .rx_fc_en);
	sgc_spi_host host (.core_clk, .spi_clk, .spi_cs_b, .spi_mosi, .spi_miso);
	// free-running core clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// value compare, four-state exact
	task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// register write and checked read over spi
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] x;
		host.xfer(SPI_CMD_WR, a, d, x);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] x;
		host.xfer(SPI_CMD_RD, a, 8'h00, x);
		chk(nm, 10'(e), 10'(x));
	endtask
	// reset with given straps, then change straps late
	task automatic do_reset(input logic [2:0] st);
		@(posedge core_clk) rst_b <= 1'b0;
		{port5_if_strap, aging_en_strap, pause_dis_strap} <= st;
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		{port5_if_strap, aging_en_strap, pause_dis_strap} <= ~st; // must be ignored
		@(posedge core_clk);
	endtask
	// one header, verdict one cycle later
	task automatic frm(input logic [15:0] t, input logic [47:0] da, input logic fc, input logic er,
		input logic [15:0] al, input logic e);
		@(posedge core_clk) frame_hdr <= '{1'b1, t, da, fc, er, al};
		@(posedge core_clk) frame_hdr.valid <= 1'b0;
		#1 chk("verdict_valid", 10'h1, 10'(verdict_valid));
		chk("verdict_drop", 10'(e), 10'(verdict_drop));
	endtask
	// strap defaults under both strap levels
	task automatic t_straps();
		do_reset(3'b110);
		rdc("gc0", GC0_ADDR, 8'h4C);
		rdc("gc1", GC1_ADDR, 8'h04);
		chk("aging_on", 10'h1, 10'(aging_on));
		do_reset(3'b001);
		rdc("gc0", GC0_ADDR, 8'h44);
		rdc("gc1", GC1_ADDR, 8'h30);
		chk("aging_on", 10'h0, 10'(aging_on));
	endtask
	// reserved bits, refused command, unmapped place
	task automatic t_regs();
		logic [7:0] x;
		wr(GC0_ADDR, 8'hC4);
		rdc("gc0", GC0_ADDR, 8'hC4);
		chk("spi_miso_oe_b", 10'h1, 10'(spi_miso_oe_b));
		host.xfer(8'h5A, GC0_ADDR, 8'h00, x);
		rdc("gc0", GC0_ADDR, 8'hC4);
		wr(8'h04, 8'hFF);
		rdc("unmapped", 8'h04, 8'h00);
		wr(GC1_ADDR, 8'h43);
		rdc("gc1", GC1_ADDR, 8'h43);
		chk("tx_fc_en", 10'h1, 10'(tx_fc_en));
	endtask
	// priority threshold sweep
	task automatic t_prio();
		for (int b = 0; b < 8; b += 3) begin
			wr(GC0_ADDR, {1'b0, 3'(b), 4'h4});
			for (int u = 0; u < 8; u++) begin
				@(posedge core_clk) user_prio <= 3'(u);
				tag_valid <= 1'b1;
				@(posedge core_clk) tag_valid <= 1'b0;
				#1 chk("prio_high", 10'(u >= b), 10'(prio_high));
				chk("prio_valid", 10'h1, 10'(prio_valid));
			end
		end
	endtask
	// port-5 isolation and buffer cap
	task automatic t_port5();
		wr(GC0_ADDR, 8'h4C);
		@(posedge core_clk) p5_core_out <= 8'h5A;
		repeat (2) @(posedge core_clk);
		#1 chk("p5_pin_out", 10'h5A, 10'(p5_pin_out));
		chk("p5_pin_oe_b", 10'h0, 10'(p5_pin_oe_b));
		chk("buf_port_limit", 10'(POOL_BLOCKS), buf_port_limit);
		wr(GC0_ADDR, 8'h40);
		chk("p5_pin_oe_b", 10'hFF, 10'(p5_pin_oe_b));
		chk("p5_pin_out", 10'h0, 10'(p5_pin_out));
		chk("buf_port_limit", 10'(POOL_FIFTH), buf_port_limit);
	endtask
	// drop decisions per mode
	task automatic t_drop();
		wr(GC0_ADDR, 8'h46);
		frm(PAUSE_TYPE, DA, 1'b0, 1'b0, 16'h0040, 1'b1);
		frm(16'h0800, PAUSE_DA, 1'b0, 1'b0, 16'h0040, 1'b1);
		frm(16'h0800, DA, 1'b0, 1'b0, 16'h0040, 1'b0);
		wr(GC0_ADDR, 8'h44);
		frm(PAUSE_TYPE, DA, 1'b0, 1'b0, 16'h0040, 1'b0);
		frm(PAUSE_TYPE, DA, 1'b1, 1'b0, 16'h0040, 1'b1);
		frm(16'h0800, DA, 1'b0, 1'b1, 16'h0040, 1'b1);
		frm(16'h0040, DA, 1'b0, 1'b0, 16'h0041, 1'b0);
		wr(GC1_ADDR, 8'h08);
		frm(16'h0040, DA, 1'b0, 1'b0, 16'h0040, 1'b0);
		frm(16'h0040, DA, 1'b0, 1'b0, 16'h0041, 1'b1);
		frm(LEN_LIMIT, DA, 1'b0, 1'b0, 16'h0010, 1'b0);
		frm(16'h05DB, DA, 1'b0, 1'b0, 16'h0010, 1'b1);
		wr(GC1_ADDR, 8'h88);
		frm(16'h0800, DA, 1'b0, 1'b1, 16'h0040, 1'b0);
		frm(16'h05DB, DA, 1'b0, 1'b0, 16'h0010, 1'b0);
	endtask
	// each pause disable on its own, then negotiation off
	task automatic t_pause();
		for (int v = 0; v < 4; v++) begin
			wr(GC1_ADDR, {2'b00, 2'(v), 4'h4});
			chk("tx_fc_en", 10'(v < 2), 10'(tx_fc_en));
			chk("rx_fc_en", 10'(v % 2 == 0), 10'(rx_fc_en));
		end
		@(posedge core_clk) an_tx_pause <= 1'b0;
		an_rx_pause <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 chk("tx_fc_en", 10'h0, 10'(tx_fc_en));
		chk("rx_fc_en", 10'h0, 10'(rx_fc_en));
	endtask
	// bounded wait for a pulse, counting cycles
	task automatic wait_hi(ref logic s, input int lim, output int n);
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(posedge core_clk);
			n++;
		end
	endtask
	// link loss, fast cycle, return to normal, aging off
	task automatic t_age();
		int n;
		wr(GC0_ADDR, 8'h45);
		@(posedge core_clk) link_up <= 5'h1B;
		wait_hi(flush_all, 4, n);
		chk("flush_all", 10'h1, 10'(flush_all));
		@(posedge core_clk);
		chk("fast_age_active", 10'h1, 10'(fast_age_active));
		wait_hi(age_tick, 12, n);
		chk("fast age_tick", 10'h1, 10'(age_tick));
		repeat (2) @(posedge core_clk);
		chk("fast_age_active", 10'h0, 10'(fast_age_active));
		wait_hi(age_tick, 60, n);
		chk("normal span", 10'h1, 10'(n > NORM - 4 && n <= NORM + 4));
		wr(GC0_ADDR, 8'h44);
		@(posedge core_clk) link_up <= 5'h1A;
		wait_hi(flush_all, 4, n);
		chk("flush_all", 10'h1, 10'(flush_all));
		@(posedge core_clk);
		chk("fast_age_active", 10'h0, 10'(fast_age_active));
		wr(GC1_ADDR, 8'h00);
		n = 0;
		repeat (100) @(posedge core_clk) n += int'(age_tick === 1'b1);
		chk("age ticks off", 10'h0, 10'(n));
	endtask
	// verdict and end of run
	task automatic test_done();
		if (failures == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// hang guard, well above the expected run
	initial begin
		repeat (40000) @(posedge core_clk);
		failures++;
		test_done();
	end
	// main sequence
	initial begin
		{rst_b, tag_valid, user_prio, p5_core_out, frame_hdr} = '0;
		{port5_if_strap, aging_en_strap, pause_dis_strap} = 3'h0;
		{link_up, an_tx_pause, an_rx_pause} = '1;
		t_straps();
		t_regs();
		t_prio();
		t_port5();
		t_drop();
		t_pause();
		t_age();
		test_done();
	end
endmodule
`default_nettype wire
